// [dcp_host.sv]
// host model: issues I/O port reads and writes
`timescale 1ns/10ps
`default_nettype none
module dcp_host (
   // clock
   input  wire logic        clk_i,
   // system bus
   input  wire logic [15:0] data_n_i,
   output logic      [7:0]  addr_n_o,
   output logic             rd_o,
   output logic             wr_o,
   output logic      [15:0] data_n_o
);
   initial begin
      addr_n_o = 8'hFF;
      rd_o = 1'h0;
      wr_o = 1'h0;
      data_n_o = 16'hFFFF;
   end
   // strobe holds over the take edge and one more, then drops a cycle
   task automatic io(input logic rd, input logic [7:0] a,
                     input logic [7:0] d, output logic [15:0] q);
      @(negedge clk_i);
      addr_n_o = ~a;
      data_n_o = {8'hFF, ~d};
      rd_o = rd;
      wr_o = !rd;
      @(posedge clk_i);
      @(negedge clk_i);
      q = data_n_i;
      @(posedge clk_i);
      @(negedge clk_i);
      rd_o = 1'h0;
      wr_o = 1'h0;
      // released lines show the inverse, never the last value
      addr_n_o = a;
      data_n_o = ~data_n_o;
      @(posedge clk_i);
      @(negedge clk_i);
   endtask
endmodule
`default_nettype wire

// [dcp_pkg.sv]
// package: constants for the diskette channel command port
package dcp_pkg;
   localparam int unsigned DCP_ADDR_W  = 8;
   localparam int unsigned DCP_BASE_W  = 5;
   localparam int unsigned DCP_CMD_W   = 3;
   localparam int unsigned DCP_DATA_W  = 8;
   localparam int unsigned DCP_UA_W    = 9;
   localparam int unsigned DCP_UW_W    = 32;
   localparam int unsigned DCP_UDEPTH  = 512;
   localparam int unsigned DCP_PTR_W   = 16;
   localparam int unsigned DCP_ROUT_W  = 4;

   // command offsets (three low address bits)
   localparam logic [2:0] OFS_STATUS   = 3'h0;
   localparam logic [2:0] OFS_PTR_LOW  = 3'h1;
   localparam logic [2:0] OFS_RES_TYPE = 3'h1;
   localparam logic [2:0] OFS_PTR_HIGH = 3'h2;
   localparam logic [2:0] OFS_STOP     = 3'h3;
   localparam logic [2:0] OFS_RES_BYTE = 3'h3;
   localparam logic [2:0] OFS_RESET    = 3'h7;

   // status byte bit positions
   localparam int unsigned ST_RDY0    = 0;
   localparam int unsigned ST_RDY1    = 1;
   localparam int unsigned ST_INT     = 2;
   localparam int unsigned ST_PRESENT = 3;

   // routine selection: channel commands then diskette operations
   localparam logic [3:0] ROUT_OP_BASE = 4'h3;

   typedef enum logic [1:0] {
      DCP_SEQ_IDLE,
      DCP_SEQ_CMD,
      DCP_SEQ_OP
   } dcp_seq_t;
endpackage

// [dcp_port.sv]
// top: diskette channel command port with decode, latches and sequencer
`timescale 1ns/10ps
`default_nettype none

module dcp_port (
   // clock and reset
   input  wire logic                             ref_clk_i,
   input  wire logic                             rst_i,
   input  wire logic                             ce_i,
   // host bus, active low address and data as on the bus
   input  wire logic [dcp_pkg::DCP_ADDR_W-1:0]   bus_addr_n_i,
   input  wire logic                             bus_read_strobe_i,
   input  wire logic                             bus_write_strobe_i,
   input  wire logic [2*dcp_pkg::DCP_DATA_W-1:0] bus_data_n_i,
   input  wire logic [dcp_pkg::DCP_BASE_W-1:0]   base_switch_i,
   output logic      [2*dcp_pkg::DCP_DATA_W-1:0] bus_data_n_o,
   output logic      [2*dcp_pkg::DCP_DATA_W-1:0] bus_data_oe_n_o,
   output logic      [dcp_pkg::DCP_DATA_W-1:0]   bus_addr_lo_n_o,
   output logic                                  bus_addr_lo_oe_n_o,
   // drive interface board
   input  wire logic                             drive0_ready_i,
   input  wire logic                             drive1_ready_i,
   output logic                                  int_n_o,
   output logic                                  status_read_n_o,
   output logic                                  result_type_read_n_o,
   output logic                                  result_read_n_o,
   output logic                                  write_sub_low_n_o,
   output logic                                  write_sub_high_n_o,
   output logic                                  set_stop_n_o,
   output logic                                  stop_n_o,
   output logic                                  channel_reset_n_o,
   // processing slices and microcode
   input  wire logic                             int_complete_i,
   input  wire logic                             int_ready_change_i,
   input  wire logic                             int_ctrl_disable_i,
   input  wire logic                             stop_clear_i,
   input  wire logic                             op_select_i,
   input  wire logic [dcp_pkg::DCP_DATA_W-1:0]   slice_data_i,
   input  wire logic                             route_addr_i,
   input  wire logic                             route_low_i,
   input  wire logic                             route_high_i,
   input  wire logic                             route_from_high_i,
   input  wire logic [dcp_pkg::DCP_DATA_W-1:0]   result_word_i,
   input  wire logic                             ucode_we_i,
   input  wire logic [dcp_pkg::DCP_UA_W-1:0]     ucode_waddr_i,
   input  wire logic [dcp_pkg::DCP_UW_W-1:0]     ucode_wdata_i,
   input  wire logic [dcp_pkg::DCP_UA_W-1:0]     uaddr_i,
   output logic      [dcp_pkg::DCP_UW_W-1:0]     uword_o,
   output logic      [dcp_pkg::DCP_CMD_W-1:0]    cmd_code_o,
   output logic                                  cmd_pending_o,
   output logic      [dcp_pkg::DCP_ROUT_W-1:0]   routine_o,
   output logic                                  routine_valid_o,
   output logic      [dcp_pkg::DCP_PTR_W-1:0]    param_pointer_o,
   output logic                                  start_o,
   output logic      [dcp_pkg::DCP_DATA_W-1:0]   memory_data_in_n_o
);
   import dcp_pkg::*;

   // ==========================================================
   // decode helpers
   // ==========================================================
   function automatic logic [7:0] onehot8(input logic [2:0] sel);
      logic [7:0] v;
      v = '0;
      v[sel] = 1'b1;
      return v;
   endfunction

   function automatic logic in_set(input logic [7:0] oh,
                                   input logic [2:0] lo,
                                   input logic [2:0] hi);
      logic r;
      r = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (i >= int'(lo) && i <= int'(hi) && oh[i]) begin
            r = 1'b1;
         end
      end
      return r;
   endfunction

   // ==========================================================
   // address match and decoders
   // ==========================================================
   logic [DCP_ADDR_W-1:0] addr;
   logic [DCP_CMD_W-1:0]  low_bits;
   logic                  base_hit;
   logic [7:0]            rd_dec;
   logic [7:0]            wr_dec;
   logic                  rd_prev;
   logic                  wr_prev;
   logic                  rd_go;
   logic                  wr_go;

   assign addr     = ~bus_addr_n_i;
   assign low_bits = addr[DCP_CMD_W-1:0];
   assign base_hit = (addr[DCP_ADDR_W-1:DCP_CMD_W] == base_switch_i);
   // act once per strobe, on its leading edge
   assign rd_go    = bus_read_strobe_i && !rd_prev && base_hit;
   assign wr_go    = bus_write_strobe_i && !wr_prev && base_hit;
   assign rd_dec   = rd_go ? onehot8(low_bits) : 8'h00;
   assign wr_dec   = wr_go ? onehot8(low_bits) : 8'h00;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         rd_prev <= 1'b0;
         wr_prev <= 1'b0;
      end else if (ce_i) begin
         rd_prev <= bus_read_strobe_i;
         wr_prev <= bus_write_strobe_i;
      end
   end

   logic rd_status;
   logic rd_type;
   logic rd_byte;
   logic wr_sub_low;
   logic wr_sub_high;
   logic wr_stop;
   logic wr_reset;
   logic rd_active;

   assign rd_status   = rd_dec[OFS_STATUS];
   assign rd_type     = rd_dec[OFS_RES_TYPE];
   assign rd_byte     = rd_dec[OFS_RES_BYTE];
   assign wr_sub_low  = in_set(wr_dec, 3'h0, 3'h2);
   assign wr_sub_high = in_set(wr_dec, 3'h4, 3'h6);
   assign wr_stop     = wr_dec[OFS_STOP];
   assign wr_reset    = wr_dec[OFS_RESET];
   assign rd_active   = bus_read_strobe_i && base_hit;

   // ==========================================================
   // strobes to the interface board (one cycle, active low)
   // ==========================================================
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         status_read_n_o      <= 1'b1;
         result_type_read_n_o <= 1'b1;
         result_read_n_o      <= 1'b1;
         write_sub_low_n_o    <= 1'b1;
         write_sub_high_n_o   <= 1'b1;
         set_stop_n_o         <= 1'b1;
         channel_reset_n_o    <= 1'b1;
      end else if (ce_i) begin
         status_read_n_o      <= ~rd_status;
         result_type_read_n_o <= ~rd_type;
         result_read_n_o      <= ~(rd_type | rd_byte);
         write_sub_low_n_o    <= ~wr_sub_low;
         write_sub_high_n_o   <= ~wr_sub_high;
         set_stop_n_o         <= ~wr_stop;
         channel_reset_n_o    <= ~wr_reset;
      end
   end

   // ==========================================================
   // interrupt latch (active low)
   // ==========================================================
   logic int_due;

   // ready changes bypass the interrupt control setting
   assign int_due = int_ready_change_i ||
                    (int_complete_i && !int_ctrl_disable_i);

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         int_n_o <= 1'b1;
      end else if (ce_i) begin
         // a request in the clearing cycle wins over the clear
         if (int_due) begin
            int_n_o <= 1'b0;
         end else if (rd_type) begin
            int_n_o <= 1'b1;
         end
      end
   end

   // ==========================================================
   // stop latch, set while the set-stop line is low
   // ==========================================================
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         stop_n_o <= 1'b1;
      end else if (ce_i) begin
         if (!set_stop_n_o) begin
            stop_n_o <= 1'b0;
         end else if (stop_clear_i) begin
            stop_n_o <= 1'b1;
         end
      end
   end

   // ==========================================================
   // command latch, handed to the sequencer
   // ==========================================================
   dcp_seq_t seq_state;
   dcp_seq_t next_seq_state;
   logic     cmd_load;

   // stop/reset/status/type are pure hardware, never reach microcode
   assign cmd_load = rd_byte || wr_sub_low || wr_sub_high;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         cmd_code_o    <= '0;
         cmd_pending_o <= 1'b0;
      end else if (ce_i) begin
         if (cmd_load) begin
            cmd_code_o    <= low_bits;
            cmd_pending_o <= 1'b1;
         end else if (routine_valid_o && seq_state == DCP_SEQ_CMD) begin
            cmd_pending_o <= 1'b0;
         end
      end
   end

   // ==========================================================
   // parameter block pointer
   // ==========================================================
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         param_pointer_o <= '0;
         start_o         <= 1'b0;
      end else if (ce_i) begin
         start_o <= 1'b0;
         if (wr_dec[OFS_PTR_LOW]) begin
            param_pointer_o[DCP_DATA_W-1:0] <= ~bus_data_n_i[DCP_DATA_W-1:0];
         end
         if (wr_dec[OFS_PTR_HIGH]) begin
            param_pointer_o[DCP_PTR_W-1:DCP_DATA_W] <=
               ~bus_data_n_i[DCP_DATA_W-1:0];
            start_o <= 1'b1;
         end
      end
   end

   // ==========================================================
   // routine selection
   // ==========================================================
   always_comb begin
      next_seq_state = DCP_SEQ_IDLE;
      if (cmd_pending_o && !op_select_i) begin
         next_seq_state = DCP_SEQ_CMD;
      end else if (op_select_i) begin
         next_seq_state = DCP_SEQ_OP;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         seq_state       <= DCP_SEQ_IDLE;
         routine_o       <= '0;
         routine_valid_o <= 1'b0;
      end else if (ce_i) begin
         seq_state <= next_seq_state;
         unique case (next_seq_state)
            DCP_SEQ_CMD: begin
               // commands 1,2,3 map to routines 0..2
               routine_o       <= DCP_ROUT_W'(cmd_code_o - 3'h1);
               routine_valid_o <= 1'b1;
            end
            DCP_SEQ_OP: begin
               // eight diskette ops map to routines 3..10
               routine_o <= ROUT_OP_BASE +
                            DCP_ROUT_W'(slice_data_i[2:0]);
               routine_valid_o <= 1'b1;
            end
            DCP_SEQ_IDLE: begin
               routine_valid_o <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // microprogram store
   // ==========================================================
   dcp_ustore u_store (
      .ref_clk_i (ref_clk_i),
      .ce_i      (ce_i),
      .we_i      (ucode_we_i),
      .waddr_i   (ucode_waddr_i),
      .wdata_i   (ucode_wdata_i),
      .raddr_i   (uaddr_i),
      .rdata_o   (uword_o)
   );

   // ==========================================================
   // data routing and status/result bytes
   // ==========================================================
   logic [2*DCP_DATA_W-1:0] route_data;
   logic [1:0]              route_oe_n;
   logic [DCP_DATA_W-1:0]   addr_lo;
   logic                    addr_lo_oe_n;

   dcp_route u_route (
      .ref_clk_i       (ref_clk_i),
      .rst_i           (rst_i),
      .ce_i            (ce_i),
      .to_addr_i       (route_addr_i),
      .to_low_i        (route_low_i),
      .to_high_i       (route_high_i),
      .from_high_i     (route_from_high_i),
      .slice_data_i    (slice_data_i),
      .sys_data_i      (bus_data_n_i),
      .addr_lo_o       (addr_lo),
      .addr_lo_oe_n_o  (addr_lo_oe_n),
      .data_o          (route_data),
      .data_oe_n_o     (route_oe_n),
      .mem_data_in_n_o (memory_data_in_n_o)
   );

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         bus_addr_lo_n_o    <= '1;
         bus_addr_lo_oe_n_o <= 1'b1;
      end else if (ce_i) begin
         bus_addr_lo_n_o    <= ~addr_lo;
         bus_addr_lo_oe_n_o <= addr_lo_oe_n;
      end
   end

   // read data held while the read strobe stays on the matched port
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         bus_data_n_o    <= '1;
         bus_data_oe_n_o <= '1;
      end else if (ce_i) begin
         bus_data_n_o    <= '1;
         bus_data_oe_n_o <= '1;
         if (rd_active && low_bits == OFS_STATUS) begin
            bus_data_n_o[ST_RDY0]    <= ~drive0_ready_i;
            bus_data_n_o[ST_RDY1]    <= ~drive1_ready_i;
            bus_data_n_o[ST_INT]     <= int_n_o;
            bus_data_n_o[ST_PRESENT] <= 1'b0;
            bus_data_oe_n_o[ST_PRESENT:ST_RDY0] <= 4'h0;
         end else if (rd_active && (low_bits == OFS_RES_TYPE ||
                                    low_bits == OFS_RES_BYTE)) begin
            bus_data_n_o[DCP_DATA_W-1:0]    <= ~result_word_i;
            bus_data_oe_n_o[DCP_DATA_W-1:0] <= '0;
         end else begin
            bus_data_n_o <= ~route_data;
            bus_data_oe_n_o <= {{DCP_DATA_W{route_oe_n[1]}},
                                {DCP_DATA_W{route_oe_n[0]}}};
         end
      end
   end
endmodule
`default_nettype wire

// [dcp_port_asserts.sv]
// checker: port timing of the diskette channel command port
`timescale 1ns/10ps
`default_nettype none
module dcp_port_asserts (
   // clock and reset
   input wire logic        ref_clk_i,
   input wire logic        rst_i,
   input wire logic        ce_i,
   // host bus
   input wire logic [7:0]  bus_addr_n_i,
   input wire logic        bus_read_strobe_i,
   input wire logic        bus_write_strobe_i,
   input wire logic [15:0] bus_data_n_i,
   input wire logic [4:0]  base_switch_i,
   input wire logic [15:0] bus_data_n_o,
   // strobes and latches
   input wire logic        int_n_o,
   input wire logic        status_read_n_o,
   input wire logic        result_read_n_o,
   input wire logic        write_sub_low_n_o,
   input wire logic        write_sub_high_n_o,
   input wire logic        set_stop_n_o,
   input wire logic        stop_n_o,
   input wire logic        channel_reset_n_o,
   // slice side
   input wire logic        int_complete_i,
   input wire logic        int_ready_change_i,
   input wire logic        int_ctrl_disable_i,
   input wire logic        stop_clear_i,
   input wire logic [2:0]  cmd_code_o,
   input wire logic [15:0] param_pointer_o,
   input wire logic        start_o
);
   // ==========================================
   // take detection
   logic       rd_q;
   logic       wr_q;
   logic       hit;
   logic       rd_tk;
   logic       wr_tk;
   logic       any_tk;
   logic [2:0] ofs;
   always_ff @(posedge ref_clk_i) begin
      rd_q <= bus_read_strobe_i;
      wr_q <= bus_write_strobe_i;
   end
   assign hit = (~bus_addr_n_i[7:3] == base_switch_i) && ce_i;
   assign ofs = ~bus_addr_n_i[2:0];
   assign any_tk = (bus_read_strobe_i && !rd_q) || (bus_write_strobe_i && !wr_q);
   assign rd_tk = bus_read_strobe_i && !rd_q && hit;
   assign wr_tk = bus_write_strobe_i && !wr_q && hit;
   // ==========================================
   // assertions
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   a_foreign_quiet: assert property (any_tk && !hit |=>
      status_read_n_o && result_read_n_o && write_sub_low_n_o
      && write_sub_high_n_o && set_stop_n_o && channel_reset_n_o)
      else $error("strobe pulsed without base match");
   a_status_present: assert property (rd_tk && ofs == 3'h0 |=>
      !status_read_n_o && !bus_data_n_o[3])
      else $error("status read pulse or present bit wrong");
   a_rtype_clear: assert property (rd_tk && ofs == 3'h1
      && !int_complete_i && !int_ready_change_i |=> int_n_o && !result_read_n_o)
      else $error("result type read did not clear interrupt");
   a_rbyte_code: assert property (rd_tk && ofs == 3'h3 |=>
      cmd_code_o == 3'h3 && !result_read_n_o)
      else $error("result byte read did not latch code");
   a_int_set: assert property (ce_i && (int_ready_change_i
      || (int_complete_i && !int_ctrl_disable_i)) |=> !int_n_o)
      else $error("interrupt latch not set");
   a_sub_low: assert property (wr_tk && ofs < 3'h3 |=> !write_sub_low_n_o
      && write_sub_high_n_o && cmd_code_o == $past(ofs))
      else $error("low write sub line or code wrong");
   a_sub_high: assert property (wr_tk && ofs inside {3'h4, 3'h5, 3'h6} |=>
      !write_sub_high_n_o && write_sub_low_n_o && cmd_code_o == $past(ofs))
      else $error("high write sub line or code wrong");
   a_stop_set: assert property (wr_tk && ofs == 3'h3 |=>
      !set_stop_n_o ##1 set_stop_n_o && !stop_n_o)
      else $error("stop pulse or stop latch wrong");
   a_stop_clear: assert property (ce_i && stop_clear_i && set_stop_n_o
      |=> stop_n_o)
      else $error("stop latch not cleared");
   a_reset_pulse: assert property (wr_tk && ofs == 3'h7 |=>
      !channel_reset_n_o ##1 channel_reset_n_o)
      else $error("channel reset pulse wrong");
   a_pointer_high: assert property (wr_tk && ofs == 3'h2 |=> start_o
      && param_pointer_o[15:8] == ~$past(bus_data_n_i[7:0]))
      else $error("high pointer byte or start wrong");
endmodule
`default_nettype wire

// [dcp_route.sv]
// data routing: steers slice data onto bus lanes and back
`timescale 1ns/10ps
`default_nettype none
module dcp_route (
   // clock
   input  wire logic                           ref_clk_i,
   input  wire logic                           rst_i,
   input  wire logic                           ce_i,
   // steering controls
   input  wire logic                           to_addr_i,
   input  wire logic                           to_low_i,
   input  wire logic                           to_high_i,
   input  wire logic                           from_high_i,
   // data
   input  wire logic [dcp_pkg::DCP_DATA_W-1:0] slice_data_i,
   input  wire logic [2*dcp_pkg::DCP_DATA_W-1:0] sys_data_i,
   output logic      [dcp_pkg::DCP_DATA_W-1:0] addr_lo_o,
   output logic                                addr_lo_oe_n_o,
   output logic      [2*dcp_pkg::DCP_DATA_W-1:0] data_o,
   output logic      [1:0]                     data_oe_n_o,
   output logic      [dcp_pkg::DCP_DATA_W-1:0] mem_data_in_n_o
);
   import dcp_pkg::*;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         addr_lo_o      <= '0;
         addr_lo_oe_n_o <= 1'b1;
         data_o         <= '0;
         data_oe_n_o    <= 2'b11;
      end else if (ce_i) begin
         addr_lo_o      <= slice_data_i;
         addr_lo_oe_n_o <= ~to_addr_i;
         data_o         <= {slice_data_i, slice_data_i};
         data_oe_n_o    <= {~to_high_i, ~to_low_i};
      end
   end

   // returned half is inverted, as the slices expect
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         mem_data_in_n_o <= '1;
      end else if (ce_i) begin
         mem_data_in_n_o <= from_high_i ? ~sys_data_i[2*DCP_DATA_W-1:DCP_DATA_W]
                                        : ~sys_data_i[DCP_DATA_W-1:0];
      end
   end
endmodule
`default_nettype wire

// [dcp_ustore.sv]
// microprogram store: 512 x 32, registered read data
`timescale 1ns/10ps
`default_nettype none
module dcp_ustore (
   // clock
   input  wire logic                           ref_clk_i,
   input  wire logic                           ce_i,
   // write port for loading microcode
   input  wire logic                           we_i,
   input  wire logic [dcp_pkg::DCP_UA_W-1:0]   waddr_i,
   input  wire logic [dcp_pkg::DCP_UW_W-1:0]   wdata_i,
   // read port
   input  wire logic [dcp_pkg::DCP_UA_W-1:0]   raddr_i,
   output logic      [dcp_pkg::DCP_UW_W-1:0]   rdata_o
);
   import dcp_pkg::*;

   logic [DCP_UW_W-1:0] mem [DCP_UDEPTH];

   always_ff @(posedge ref_clk_i) begin
      if (ce_i && we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (ce_i) begin
         rdata_o <= mem[raddr_i];
      end
   end
endmodule
`default_nettype wire

// [tb_diskette_channel_command_port.sv]
// testbench: command decode, latches and sequencer of the port
`timescale 1ns/10ps
`default_nettype none
module tb_diskette_channel_command_port;
   import dcp_pkg::*;
   localparam logic [4:0] BASE = 5'h0A;
   logic ref_clk_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1;
   logic [7:0] bus_addr_n_i, bus_addr_lo_n_o, memory_data_in_n_o;
   logic bus_read_strobe_i, bus_write_strobe_i, bus_addr_lo_oe_n_o;
   logic [15:0] bus_data_n_i, bus_data_n_o, bus_data_oe_n_o, param_pointer_o, q;
   logic [4:0] base_switch_i = BASE;
   logic [7:0] slice_data_i = 8'h05, result_word_i = 8'hA5, seen;
   logic drive0_ready_i = 1'h1, drive1_ready_i = 1'h0;
   logic int_n_o, status_read_n_o, result_type_read_n_o, result_read_n_o;
   logic write_sub_low_n_o, write_sub_high_n_o, set_stop_n_o, stop_n_o;
   logic channel_reset_n_o, cmd_pending_o, routine_valid_o, start_o;
   logic int_complete_i = 1'h0, int_ready_change_i = 1'h0, stop_clear_i = 1'h0;
   logic int_ctrl_disable_i = 1'h0, op_select_i = 1'h0, ucode_we_i = 1'h0;
   logic route_addr_i = 1'h0, route_low_i = 1'h0;
   logic route_high_i = 1'h0, route_from_high_i = 1'h0;
   logic [8:0] ucode_waddr_i = 9'h000, uaddr_i = 9'h000;
   logic [31:0] ucode_wdata_i = 32'h0, uword_o;
   logic [2:0] cmd_code_o;
   logic [3:0] routine_o;
   int n_mismatch = 0, comparisons = 0;
   dcp_port i_dcp_port (.*);
   dcp_host i_dcp_host (.clk_i(ref_clk_i), .data_n_i(bus_data_n_o),
      .addr_n_o(bus_addr_n_i), .rd_o(bus_read_strobe_i),
      .wr_o(bus_write_strobe_i), .data_n_o(bus_data_n_i));
   always #50 ref_clk_i = ~ref_clk_i;
   // one-cycle strobes are gathered so a task can judge them afterwards
   always @(posedge ref_clk_i) seen <= seen | {start_o, ~channel_reset_n_o,
      ~set_stop_n_o, ~write_sub_high_n_o, ~write_sub_low_n_o,
      ~result_read_n_o, ~result_type_read_n_o, ~status_read_n_o};
   // ==========================================
   // helpers
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         $display("BAD %s exp %h got %h", nm, e, g);
         n_mismatch++;
      end
   endtask
   task automatic op(input logic rd, input logic [2:0] ofs, input logic [7:0] d);
      seen = 8'h00;
      i_dcp_host.io(rd, {BASE, ofs}, d, q);
   endtask
   task automatic pulse_req(input logic [2:0] k);
      @(negedge ref_clk_i);
      {stop_clear_i, int_ready_change_i, int_complete_i} = k;
      @(negedge ref_clk_i);
      {stop_clear_i, int_ready_change_i, int_complete_i} = 3'h0;
      @(negedge ref_clk_i);
   endtask
   task test_done;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ==========================================
   // scenarios
   task automatic t_interrupt;
      op(1'h1, 3'h0, 8'h00);
      chk("status idle", 32'h6, q[3:0]);
      chk("status strobe", 32'h01, seen);
      pulse_req(3'h1);
      chk("int set", 32'h0, int_n_o);
      op(1'h1, 3'h0, 8'h00);
      chk("status int", 32'h2, q[3:0]);
      op(1'h1, 3'h1, 8'h00);
      chk("type data", 32'h5A, q[7:0]);
      chk("type strobes", 32'h06, seen);
      chk("int clear", 32'h1, int_n_o);
      int_ctrl_disable_i = 1'h1;
      pulse_req(3'h1);
      chk("int masked", 32'h1, int_n_o);
      pulse_req(3'h2);
      chk("ready change", 32'h0, int_n_o);
      op(1'h1, 3'h1, 8'h00);
      int_ctrl_disable_i = 1'h0;
   endtask
   task automatic t_commands;
      logic [2:0] o;
      op(1'h1, 3'h3, 8'h00);
      chk("byte code", 32'h3, cmd_code_o);
      chk("byte strobes", 32'h04, seen);
      op(1'h0, 3'h1, 8'h34);
      chk("low strobes", 32'h08, seen);
      op(1'h0, 3'h2, 8'h12);
      chk("high strobes", 32'h88, seen);
      chk("pointer", 32'h1234, param_pointer_o);
      chk("high code", 32'h2, cmd_code_o);
      chk("routine", 32'h11,
         {cmd_pending_o, routine_valid_o, routine_o});
      op(1'h0, 3'h3, 8'h00);
      chk("stop strobes", 32'h20, seen);
      chk("stop set", 32'h0, stop_n_o);
      chk("code kept", 32'h2, cmd_code_o);
      pulse_req(3'h4);
      chk("stop clear", 32'h1, stop_n_o);
      op(1'h0, 3'h7, 8'h00);
      chk("reset strobes", 32'h40, seen);
      for (int i = 0; i < 3; i++) begin
         o = (i == 0) ? 3'h0 : 3'h4 + 3'(i);
         op(1'h0, o, 8'h00);
         chk("sub strobes", (i == 0) ? 32'h08 : 32'h10, seen);
         chk("sub code", o, cmd_code_o);
      end
      base_switch_i = BASE ^ 5'h01;
      op(1'h0, 3'h7, 8'h00);
      chk("foreign write", 32'h00, seen);
      op(1'h1, 3'h0, 8'h00);
      chk("foreign base", 32'h00, seen);
      base_switch_i = BASE;
   endtask
   task automatic t_sequencer;
      int n;
      ucode_we_i = 1'h1;
      ucode_waddr_i = 9'h1FF;
      ucode_wdata_i = 32'hC0DE5A5A;
      @(negedge ref_clk_i);
      ucode_we_i = 1'h0;
      uaddr_i = 9'h1FF;
      repeat (2) @(negedge ref_clk_i);
      chk("ucode word", 32'hC0DE5A5A, uword_o);
      route_addr_i = 1'h1;
      route_low_i = 1'h1;
      repeat (2) @(negedge ref_clk_i);
      chk("addr", 32'h0FA, {bus_addr_lo_oe_n_o, bus_addr_lo_n_o});
      chk("oe", 32'hFF00, bus_data_oe_n_o);
      chk("data", 32'hFA, bus_data_n_o[7:0]);
      chk("mdata", 32'hFF, memory_data_in_n_o);
      op_select_i = 1'h1;
      for (n = 0; n < 8 && routine_o !== 4'h8; n++) @(negedge ref_clk_i);
      chk("op routine", 32'h8, routine_o);
      if (routine_o !== 4'h8) test_done();
      op_select_i = 1'h0;
   endtask
   initial begin
      repeat (5) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      rst_i = 1'h0;
      t_interrupt();
      t_commands();
      t_sequencer();
      test_done();
   end
endmodule
bind dcp_port dcp_port_asserts i_dcp_port_asserts (.ref_clk_i, .rst_i,
   .ce_i, .bus_addr_n_i, .bus_read_strobe_i, .bus_write_strobe_i,
   .bus_data_n_i, .base_switch_i, .bus_data_n_o, .int_n_o, .status_read_n_o,
   .result_read_n_o, .write_sub_low_n_o, .write_sub_high_n_o, .set_stop_n_o,
   .stop_n_o, .channel_reset_n_o, .int_complete_i, .int_ready_change_i,
   .int_ctrl_disable_i, .stop_clear_i, .cmd_code_o, .param_pointer_o,
   .start_o);
`default_nettype wire
